// ===== rtl/eeprom_consts.vh
// Constants for the two-wire byte memory slave: geometry, selection word, timing.
// Assumes the includer runs on a 125 MHz clock.
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// ==========================================
// Geometry
`define MEM_DEPTH        128
`define ADDR_W           7
`define PAGE_BITS        3

// ==========================================
// Selection word
`define DEV_TYPE         4'hA

// ==========================================
// Timing
`define CLK_MHZ          125
`define WRITE_CYCLE_MS   5
`define WRITE_CYCLES     (`WRITE_CYCLE_MS * 1000 * `CLK_MHZ)

`endif

// ===== rtl/two_wire_eeprom_slave.v
// Two-wire slave of a 128 x 8 byte memory with page write and timed write cycle.
// Assumes scl and sda_in are already synchronous to sys_clk and slower than it by far.
// The array has no reset and starts unknown; write protect still acknowledges data.
// Stops inside the write cycle are ignored, so a controller must poll for completion.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.vh"

module two_wire_eeprom_slave
#(
  parameter [31:0] WRITE_CYCLES = `WRITE_CYCLES
)
(
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       scl,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       select_pin_high,
  input  wire       select_pin_mid,
  input  wire       select_pin_low,
  input  wire       write_protect,
  output reg        standby,
  output reg        write_busy
);

  // ==========================================
  // States
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_SEL   = 3'd1;
  localparam [2:0] ST_ADDR  = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_MACK  = 3'd5;

  // ==========================================
  // Storage and state
  reg [7:0]          mem [0:`MEM_DEPTH-1];
  reg [7:0]          page_buf [0:7];
  reg [7:0]          page_valid;
  reg [`ADDR_W-1:0]  addr_cnt;
  reg [`ADDR_W-1:0]  page_base;
  reg [2:0]          state;
  reg [3:0]          bit_cnt;
  reg [7:0]          shift;
  reg                ack_phase;
  reg                read_seen;
  reg                write_pending;
  reg [31:0]         wr_timer;
  reg [3:0]          flush_idx;
  reg                scl_d;
  reg                sda_d;

  // Both line samples reset to idle high, so no false edge follows reset
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_ev = scl & scl_d & sda_d & ~sda_in;
  wire stop_ev  = scl & scl_d & ~sda_d & sda_in;
  wire [7:0] byte_in = {shift[6:0], sda_in};
  wire [`PAGE_BITS-1:0] page_off   = addr_cnt[`PAGE_BITS-1:0];
  wire                  wr_done    = (wr_timer >= WRITE_CYCLES - 32'd1);
  wire                  launch     = stop_ev && !write_busy && write_pending && !write_protect;
  // Flush walks the eight page slots in the first clocks of the write cycle
  wire                  flush_en   = write_busy && (flush_idx < 4'd8);
  wire [`ADDR_W-1:0]    flush_addr = {page_base[`ADDR_W-1:`PAGE_BITS], flush_idx[2:0]};

  function [`ADDR_W-1:0] page_inc;
    input [`ADDR_W-1:0] a;
    begin
      page_inc = {a[`ADDR_W-1:`PAGE_BITS], a[`PAGE_BITS-1:0] + 3'd1};
    end
  endfunction

  function sel_match;
    input [7:0] w;
    begin
      sel_match = (w[7:4] == `DEV_TYPE) &&
        (w[3:1] == {select_pin_high, select_pin_mid, select_pin_low});
    end
  endfunction

  // Open drain: the line is pulled low for a zero bit only
  function drive_low;
    input [7:0] w;
    input [2:0] n;
    begin
      drive_low = ~w[n];
    end
  endfunction

  // ==========================================
  // Line sampling
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda_in;
    end
  end

  // ==========================================
  // Protocol engine
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= ST_IDLE;
      bit_cnt       <= 4'h0;
      shift         <= 8'h00;
      ack_phase     <= 1'b0;
      read_seen     <= 1'b0;
      addr_cnt      <= 7'h00;
      page_base     <= 7'h00;
      page_valid    <= 8'h00;
      write_pending <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      standby       <= 1'b1;
    end
    else
    begin
      if (write_busy)
      begin
        // Inputs ignored while programming, so a poll gets no acknowledge
        sda_oe <= 1'b0;
        state  <= ST_IDLE;
        if (wr_done)
        begin
          standby    <= 1'b1;
          page_valid <= 8'h00;
        end
      end
      else if (stop_ev)
      begin
        state   <= ST_IDLE;
        sda_oe  <= 1'b0;
        // A protected page is dropped here and standby follows at once
        if (!launch)
        begin
          standby <= 1'b1;
        end
        write_pending <= 1'b0;
        read_seen     <= 1'b0;
      end
      else if (start_ev)
      begin
        // A fresh start resynchronises whenever no write cycle runs, which gives the bus recovery sequence
        state         <= ST_SEL;
        bit_cnt       <= 4'h0;
        ack_phase     <= 1'b0;
        sda_oe        <= 1'b0;
        standby       <= 1'b0;
        write_pending <= 1'b0;
        page_valid    <= 8'h00;
      end
      else if (state != ST_IDLE)
      begin
        if (scl_rise && !ack_phase)
        begin
          // A byte being sent must not be shifted by its own echo on the line
          if (state != ST_RDATA)
          begin
            shift <= byte_in;
          end
          bit_cnt <= bit_cnt + 4'd1;
          // Controller acknowledge sampled here; an acknowledge waits in ST_MACK
          // for the fall, which loads the next byte, so no stale bit goes out
          if (state == ST_MACK && sda_in)
          begin
            state <= ST_IDLE;
          end
        end
        else if (scl_fall)
        begin
          if (ack_phase)
          begin
            // End of the acknowledge clock: release or start the next byte
            ack_phase <= 1'b0;
            bit_cnt   <= 4'h0;
            sda_oe    <= 1'b0;
            if (state == ST_RDATA)
            begin
              sda_oe  <= drive_low(mem[addr_cnt], 3'd7);
              sda_out <= 1'b0;
              shift   <= mem[addr_cnt];
            end
          end
          else if (state == ST_RDATA)
          begin
            if (bit_cnt == 4'd8)
            begin
              sda_oe   <= 1'b0;
              state    <= ST_MACK;
              bit_cnt  <= 4'h0;
              addr_cnt <= addr_cnt + 7'd1;
            end
            else
            begin
              sda_oe <= drive_low(shift, 3'd7 - bit_cnt[2:0]);
            end
          end
          else if (state == ST_MACK)
          begin
            // Acknowledged: the next byte goes out from the advanced counter
            state   <= ST_RDATA;
            bit_cnt <= 4'h0;
            shift   <= mem[addr_cnt];
            sda_oe  <= drive_low(mem[addr_cnt], 3'd7);
          end
          else if (bit_cnt == 4'd8)
          begin
            case (state)
              ST_SEL:
              begin
                if (sel_match(shift))
                begin
                  sda_oe    <= 1'b1;
                  ack_phase <= 1'b1;
                  if (shift[0])
                  begin
                    state     <= ST_RDATA;
                    read_seen <= 1'b1;
                  end
                  else
                  begin
                    state <= ST_ADDR;
                  end
                end
                else
                begin
                  state   <= ST_IDLE;
                  standby <= 1'b1;
                end
              end
              ST_ADDR:
              begin
                // Bit 7 is dropped; seven bits reach every byte
                addr_cnt  <= shift[`ADDR_W-1:0];
                page_base <= shift[`ADDR_W-1:0];
                sda_oe    <= 1'b1;
                ack_phase <= 1'b1;
                state     <= ST_WDATA;
              end
              ST_WDATA:
              begin
                page_buf[page_off]   <= shift;
                page_valid[page_off] <= 1'b1;
                page_base     <= addr_cnt;
                addr_cnt      <= page_inc(addr_cnt);
                write_pending <= 1'b1;
                sda_oe        <= 1'b1;
                ack_phase     <= 1'b1;
              end
              default:
              begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  // ==========================================
  // Self-timed write cycle
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_busy <= 1'b0;
      wr_timer   <= 32'h0;
      flush_idx  <= 4'h0;
    end
    else if (launch)
    begin
      // Counted from the launching stop; polls see busy until the last count
      write_busy <= 1'b1;
      wr_timer   <= 32'h0;
      flush_idx  <= 4'h0;
    end
    else if (write_busy)
    begin
      if (flush_en)
      begin
        flush_idx <= flush_idx + 4'd1;
      end
      if (wr_done)
      begin
        write_busy <= 1'b0;
      end
      else
      begin
        wr_timer <= wr_timer + 32'd1;
      end
    end
  end

  // ==========================================
  // Array programming from the page buffer
  always @(posedge sys_clk)
  begin
    // Only bytes received in this frame land; the rest of the page keeps its data
    if (flush_en && page_valid[flush_idx[2:0]])
    begin
      mem[flush_addr] <= page_buf[flush_idx[2:0]];
    end
  end

endmodule // two_wire_eeprom_slave

`default_nettype wire

// ===== verif/two_wire_eeprom_slave_sva.sv
// Port assertions for the two-wire memory slave.
// Assumes one clock domain and a shortened write cycle count.
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_sva
#(
  parameter [31:0] WRITE_CYCLES = 32'h190
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic standby,
  input wire logic write_busy
);
  reg [31:0] busy_cnt;
  // Counter, since the write length is far beyond a repetition count
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= write_busy ? busy_cnt + 32'h1 : 32'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  open_drain_a: assert property (!sda_out) else $error("data driven high");
  busy_quiet_a: assert property (write_busy |-> !sda_oe) else $error("answer while busy");
  out_edge_a: assert property ($changed(sda_oe) |-> !scl) else $error("data moved, clock high");
  busy_len_a: assert property (write_busy |-> busy_cnt <= WRITE_CYCLES)
    else $error("write cycle too long");
  busy_done_a: assert property ($fell(write_busy) |-> ##[0:2] standby)
    else $error("no standby after write");
  stop_idle_a: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:4] (standby || write_busy))
    else $error("no standby after stop");
  ack_awake_a: assert property ($rose(sda_oe) |-> !standby) else $error("answer from standby");
  busy_launch_a: assert property ($rose(write_busy) |-> scl && $past(scl, 2))
    else $error("write launched without stop");
endmodule // eeprom_slave_sva
bind two_wire_eeprom_slave eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) sva_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .standby(standby), .write_busy(write_busy));
`default_nettype wire

// ===== verif/bus_controller.sv
// Behavioural two-wire bus controller, driven by tasks from the bench.
// Assumes a pull-up on the data line; sda_low high pulls it down.
`timescale 1ns/1ps
`default_nettype none
module bus_controller
#(
  parameter int HALF = 5
)
(
  input  wire logic sys_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Also serves as repeated start: data is released before the clock rises
  task automatic start();
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
    tick(1);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
endmodule // bus_controller
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the two-wire memory slave.
// Assumes the controller model drives scl and pulls data low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       write_protect = 1'b0;
  logic [2:0] pins = 3'h5;
  logic [7:0] q;
  logic       a;
  int         failures = 0;
  int         checks = 0;
  wire logic  scl, sda_low, sda_out, sda_oe, standby, write_busy;
  wire logic  sda = !(sda_low || sda_oe);
  always #4 sys_clk = ~sys_clk;
  bus_controller ctl (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  two_wire_eeprom_slave #(.WRITE_CYCLES(32'h190)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(pins[2]),
    .select_pin_mid(pins[1]), .select_pin_low(pins[0]), .write_protect(write_protect),
    .standby(standby), .write_busy(write_busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {4'hA, pins, rw};
  endfunction
  task automatic send(input logic [7:0] d, input logic [7:0] ack);
    ctl.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, ack);
  endtask
  task automatic rd(input logic more, input logic [7:0] exp);
    ctl.xfer(8'hFF, !more, q, a);
    chk(q, exp);
  endtask
  task automatic addr_at(input logic [7:0] w);
    ctl.start();
    send(dev(1'b0), 8'h00);
    send(w, 8'h00);
  endtask
  task automatic wait_write();
    for (int n = 0; n < 600 && write_busy !== 1'b0; n++) ctl.tick(1);
    chk({7'h0, write_busy}, 8'h00);
    chk({7'h0, sda_out}, 8'h00);
    chk({7'h0, standby}, 8'h01);
  endtask
  task automatic wbyte(input logic [7:0] w, input logic [7:0] d);
    addr_at(w);
    send(d, 8'h00);
    ctl.stop();
    wait_write();
  endtask
  task automatic rd_one(input logic [7:0] exp);
    ctl.start();
    send(dev(1'b1), 8'h00);
    rd(1'b0, exp);
    ctl.stop();
  endtask
  task automatic t_page();
    addr_at(8'h8D);
    for (int i = 0; i < 10; i++) send(8'h30 + 8'(i), 8'h00);
    ctl.stop();
    chk({7'h0, write_busy}, 8'h01);
    ctl.start();
    send(dev(1'b0), 8'h01);
    ctl.stop();
    wait_write();
    ctl.start();
    send(dev(1'b0), 8'h00);
    ctl.stop();
    rd_one(8'h32);
    $display("t_page done");
  endtask
  task automatic t_seq();
    logic [7:0] exp [8] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h32};
    addr_at(8'h08);
    ctl.start();
    send(dev(1'b1), 8'h00);
    for (int k = 0; k < 8; k++) rd(k < 7, exp[k]);
    ctl.stop();
    chk({7'h0, standby}, 8'h01);
    $display("t_seq done");
  endtask
  task automatic t_wrap();
    wbyte(8'h7F, 8'h5A);
    wbyte(8'h00, 8'hC3);
    addr_at(8'h7F);
    rd_one(8'h5A);
    rd_one(8'hC3);
    $display("t_wrap done");
  endtask
  task automatic t_protect();
    write_protect = 1'b1;
    wbyte(8'h0D, 8'hEE);
    write_protect = 1'b0;
    addr_at(8'h0D);
    rd_one(8'h38);
    $display("t_protect done");
  endtask
  task automatic t_select();
    for (int p = 0; p < 8; p++)
    begin
      ctl.start();
      send({4'hA, 3'(p), 1'b0}, {7'h0, 3'(p) != pins});
      ctl.stop();
    end
    ctl.start();
    send({4'hB, pins, 1'b1}, 8'h01);
    ctl.stop();
    chk({7'h0, standby}, 8'h01);
    // Broken frame, then the recovery sequence
    ctl.start();
    repeat (3) ctl.bit_io(1'b0, a);
    ctl.start();
    repeat (9) ctl.bit_io(1'b1, a);
    ctl.start();
    ctl.stop();
    addr_at(8'h0F);
    rd_one(8'h32);
    $display("t_select done");
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    ctl.tick(2);
    t_page();
    t_seq();
    t_wrap();
    t_protect();
    t_select();
    end_of_test();
  end
  initial
  begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
